// ### core/boot_mode_select_flash_map.sv
// Purpose: Latch boot mode from pins, map flash blocks, gate rewrite
// Assumes: Pins and requests synchronous to clk; srst held >= 20 cycles
// Notes: Outputs registered; decode result valid one cycle after request
// Notes on behaviour
// - Mode taken from four select pins
// - After reset run in chosen mode
// - Single-chip mode fetches from internal flash
// - Single-chip splits into normal and user rewrite
// - Serial boot starts from internal boot ROM
// - Program/erase only in on-board programming modes
// - Blocks 0-5 at F80000, 64 KB each
// - Blocks 6-7 56 KB, 8-9 8 KB
// - Serial boot remaps blocks contiguously from 010000
// - No flash data returned during program/erase
// - Ten protectable blocks, 32-bit read path
module boot_mode_select_flash_map #(
  parameter int DATA_W = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic mode_sel_pin_a,
  input wire logic mode_sel_pin_b,
  input wire logic factory_sel_pin_a,
  input wire logic factory_sel_pin_b,
  input wire logic user_rewrite_req,
  input wire logic [9:0] protect_set,
  input wire logic [9:0] protect_clr,
  input wire logic rd_req,
  input wire logic [23:0] rd_addr,
  input wire logic [DATA_W-1:0] flash_rdata,
  input wire logic flash_busy,
  input wire logic pgm_req,
  input wire logic [23:0] pgm_addr,
  output logic mode_valid,
  output logic serial_boot,
  output logic fetch_boot_rom,
  output logic user_rewrite,
  output logic onboard_pgm,
  output logic [9:0] block_protect,
  output logic rd_hit,
  output logic [3:0] rd_block,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_blocked,
  output logic pgm_grant,
  output logic pgm_deny
);
  if (DATA_W != 32) begin : g_width_chk
    $error("Flash read path must be 32 bits");
  end

  typedef struct packed {
    logic in_reset;
    boot_map_pkg::op_mode_t mode;
    logic mode_valid;
    logic serial_boot;
    logic fetch_boot_rom;
    logic user_rewrite;
    logic onboard_pgm;
    logic [9:0] block_protect;
    logic rd_hit;
    logic [3:0] rd_block;
    logic [DATA_W-1:0] rd_data;
    logic rd_blocked;
    logic pgm_grant;
    logic pgm_deny;
  } state_t;

  state_t st_reg, st_next;

  // Block lookup for an address in the given mode
  function automatic logic [4:0] lookup(input logic [23:0] a,
                                        input logic boot);
    logic [4:0] r;
    logic [23:0] b;
    r = '0;
    b = '0;
    for (int i = 0; i < boot_map_pkg::NUM_BLOCKS; i++) begin
      b = boot ? boot_map_pkg::BOOT_BASE[i] : boot_map_pkg::CHIP_BASE[i];
      if (a >= b && a - b < boot_map_pkg::BLK_SIZE[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  logic [3:0] pins;
  logic [4:0] rd_lk;
  logic [4:0] pg_lk;
  logic rd_go;
  assign rd_go = rd_req && !flash_busy && !st_reg.in_reset;
  assign pins = {factory_sel_pin_a, factory_sel_pin_b,
                 mode_sel_pin_a, mode_sel_pin_b};
  assign rd_lk = lookup(rd_addr, st_reg.serial_boot);
  assign pg_lk = lookup(pgm_addr, st_reg.serial_boot);

  always_comb begin
    st_next = st_reg;
    st_next.in_reset = 1'b0;
    st_next.rd_hit = 1'b0;
    st_next.rd_blocked = 1'b0;
    st_next.pgm_grant = 1'b0;
    st_next.pgm_deny = 1'b0;
    if (st_reg.in_reset) begin
      // First cycle after release captures pins
      if (pins == boot_map_pkg::PINS_SERIAL_BOOT) begin
        st_next.mode = boot_map_pkg::MODE_SERIAL_BOOT;
      end else if (pins == boot_map_pkg::PINS_SINGLE_CHIP) begin
        st_next.mode = boot_map_pkg::MODE_SINGLE_CHIP;
      end else begin
        st_next.mode = boot_map_pkg::MODE_INVALID;
      end
      st_next.mode_valid = (pins == boot_map_pkg::PINS_SERIAL_BOOT) ||
                           (pins == boot_map_pkg::PINS_SINGLE_CHIP);
      st_next.serial_boot = (pins == boot_map_pkg::PINS_SERIAL_BOOT);
      st_next.fetch_boot_rom = (pins == boot_map_pkg::PINS_SERIAL_BOOT);
      st_next.onboard_pgm = (pins == boot_map_pkg::PINS_SERIAL_BOOT);
    end else begin
      // Software enters user rewrite from normal mode
      if (st_reg.mode == boot_map_pkg::MODE_SINGLE_CHIP && user_rewrite_req) begin
        st_next.user_rewrite = 1'b1;
        st_next.onboard_pgm = 1'b1;
      end
      // Block protect, set wins over clear
      st_next.block_protect = (st_reg.block_protect & ~protect_clr)
                              | protect_set;
      if (rd_req) begin
        if (flash_busy) begin
          st_next.rd_blocked = 1'b1;
          st_next.rd_data = '0;
        end else if (rd_lk[4]) begin
          st_next.rd_hit = 1'b1;
          st_next.rd_block = rd_lk[3:0];
          st_next.rd_data = flash_rdata;
        end
      end
      if (pgm_req) begin
        if (st_reg.onboard_pgm && pg_lk[4] &&
            !st_reg.block_protect[pg_lk[3:0]]) begin
          st_next.pgm_grant = 1'b1;
        end else begin
          st_next.pgm_deny = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.in_reset <= 1'b1;
      st_reg.mode <= boot_map_pkg::MODE_INVALID;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mode_valid = st_reg.mode_valid;
  assign serial_boot = st_reg.serial_boot;
  assign fetch_boot_rom = st_reg.fetch_boot_rom;
  assign user_rewrite = st_reg.user_rewrite;
  assign onboard_pgm = st_reg.onboard_pgm;
  assign block_protect = st_reg.block_protect;
  assign rd_hit = st_reg.rd_hit;
  assign rd_block = st_reg.rd_block;
  assign rd_data = st_reg.rd_data;
  assign rd_blocked = st_reg.rd_blocked;
  assign pgm_grant = st_reg.pgm_grant;
  assign pgm_deny = st_reg.pgm_deny;

  sequence s_release;
    $fell(srst);
  endsequence

  sequence s_latched;
    !st_reg.in_reset && !$past(st_reg.in_reset);
  endsequence

  a_mode_hold: assert property (@(posedge clk) disable iff (srst)
    s_latched |-> $stable(serial_boot))
    else $error("Mode changed after latch");

  a_valid_hold: assert property (@(posedge clk) disable iff (srst)
    s_latched |-> $stable(mode_valid) && $stable(fetch_boot_rom))
    else $error("Mode validity changed after latch");

  a_mode_latch: assert property (@(posedge clk) disable iff (srst)
    s_release |=> serial_boot ==
      ($past(pins) == boot_map_pkg::PINS_SERIAL_BOOT))
    else $error("Serial boot not latched at release");

  a_valid_latch: assert property (@(posedge clk) disable iff (srst)
    s_release |=> mode_valid ==
      ($past(pins) == boot_map_pkg::PINS_SERIAL_BOOT ||
       $past(pins) == boot_map_pkg::PINS_SINGLE_CHIP))
    else $error("Mode validity not latched at release");

  a_reset_quiet: assert property (@(posedge clk)
    srst |=> !mode_valid && !serial_boot && !onboard_pgm &&
      !user_rewrite && !rd_hit && !pgm_grant)
    else $error("Outputs active after reset");

  a_boot_rom_fetch: assert property (@(posedge clk) disable iff (srst)
    fetch_boot_rom == serial_boot)
    else $error("Fetch source disagrees with mode");

  a_rom_single: assert property (@(posedge clk) disable iff (srst)
    !serial_boot |-> !fetch_boot_rom)
    else $error("Boot ROM fetch outside serial boot");

  a_pgm_gate: assert property (@(posedge clk) disable iff (srst)
    pgm_grant |-> onboard_pgm)
    else $error("Program granted outside on-board mode");

  a_pgm_answer: assert property (@(posedge clk) disable iff (srst)
    pgm_req && !st_reg.in_reset |=> pgm_grant || pgm_deny)
    else $error("Program request left unanswered");

  a_grant_excl: assert property (@(posedge clk) disable iff (srst)
    !(pgm_grant && pgm_deny))
    else $error("Program granted and denied together");

  a_pgm_unmapped: assert property (@(posedge clk) disable iff (srst)
    pgm_req && !st_reg.in_reset && !pg_lk[4] |=> pgm_deny)
    else $error("Program outside flash not denied");

  a_pgm_protect: assert property (@(posedge clk) disable iff (srst)
    pgm_req && !st_reg.in_reset && pg_lk[4] &&
    block_protect[pg_lk[3:0]] |=> pgm_deny)
    else $error("Program to protected block not denied");

  a_onboard_src: assert property (@(posedge clk) disable iff (srst)
    onboard_pgm |-> serial_boot || user_rewrite)
    else $error("On-board mode without a source");

  a_protect_set: assert property (@(posedge clk) disable iff (srst)
    !st_reg.in_reset |=>
      (block_protect & $past(protect_set)) == $past(protect_set))
    else $error("Protect set lost");

  a_protect_clr: assert property (@(posedge clk) disable iff (srst)
    !st_reg.in_reset |=>
      (block_protect & $past(protect_clr) & ~$past(protect_set)) == '0)
    else $error("Protect clear ignored");

  a_busy_block: assert property (@(posedge clk) disable iff (srst)
    rd_req && flash_busy && !st_reg.in_reset
    |=> rd_blocked && !rd_hit && rd_data == '0)
    else $error("Flash data returned while busy");

  a_rd_excl: assert property (@(posedge clk) disable iff (srst)
    !(rd_hit && rd_blocked))
    else $error("Read hit and blocked together");

  a_no_req_quiet: assert property (@(posedge clk) disable iff (srst)
    !rd_req |=> !rd_hit && !rd_blocked)
    else $error("Read answer without request");

  a_hit_data: assert property (@(posedge clk) disable iff (srst)
    rd_go && rd_lk[4] |=> rd_hit && rd_data == $past(flash_rdata))
    else $error("Read data not passed through");

  a_miss_quiet: assert property (@(posedge clk) disable iff (srst)
    rd_go && !rd_lk[4] |=> !rd_hit && !rd_blocked)
    else $error("Unmapped read answered");

  a_chip_blk0: assert property (@(posedge clk) disable iff (srst)
    rd_go && !serial_boot && rd_addr == boot_map_pkg::CHIP_BASE[0]
    |=> rd_hit && rd_block == 4'h0)
    else $error("Block 0 single-chip decode wrong");

  a_chip_blk5: assert property (@(posedge clk) disable iff (srst)
    rd_go && !serial_boot &&
    rd_addr == boot_map_pkg::CHIP_BASE[6] - 24'h000001
    |=> rd_hit && rd_block == 4'h5)
    else $error("Block 5 single-chip decode wrong");

  a_chip_gap: assert property (@(posedge clk) disable iff (srst)
    rd_go && !serial_boot && rd_addr == boot_map_pkg::BOOT_BASE[0]
    |=> !rd_hit)
    else $error("Boot window hit in single-chip mode");

  a_chip_blk7: assert property (@(posedge clk) disable iff (srst)
    rd_go && !serial_boot &&
    rd_addr == boot_map_pkg::CHIP_BASE[8] - 24'h000001
    |=> rd_hit && rd_block == 4'h7)
    else $error("Block 7 single-chip decode wrong");

  a_chip_blk9: assert property (@(posedge clk) disable iff (srst)
    rd_go && !serial_boot && rd_addr == boot_map_pkg::CHIP_BASE[9]
    |=> rd_hit && rd_block == 4'h9)
    else $error("Block 9 single-chip decode wrong");

  a_boot_blk0: assert property (@(posedge clk) disable iff (srst)
    rd_go && serial_boot && rd_addr == boot_map_pkg::BOOT_BASE[0]
    |=> rd_hit && rd_block == 4'h0)
    else $error("Block 0 boot decode wrong");

  a_boot_blk9: assert property (@(posedge clk) disable iff (srst)
    rd_go && serial_boot && rd_addr == boot_map_pkg::BOOT_BASE[9] +
      boot_map_pkg::BLK_SIZE[9] - 24'h000001
    |=> rd_hit && rd_block == 4'h9)
    else $error("Block 9 boot decode wrong");

  a_user_rw: assert property (@(posedge clk) disable iff (srst)
    user_rewrite |-> !serial_boot && onboard_pgm)
    else $error("User rewrite outside single-chip");

  a_rewrite_hold: assert property (@(posedge clk) disable iff (srst)
    user_rewrite |=> user_rewrite)
    else $error("User rewrite dropped before reset");
endmodule

// ### shared/boot_map_pkg.sv
// Purpose: Constants for mode latch and flash block address mapping
// Assumes: 24-bit processor address space, ten flash blocks
// Notes: Pin encoding of modes is a local choice
package boot_map_pkg;
  localparam int ADDR_W = 24;
  localparam int NUM_BLOCKS = 10;
  localparam int BLK_IDX_W = 4;
  localparam int RESET_MIN_CYCLES = 20;
  // Window bases per mode, block order 0..9
  localparam logic [23:0] CHIP_BASE [10] = '{
    24'hF80000, 24'hF90000, 24'hFA0000, 24'hFB0000, 24'hFC0000,
    24'hFD0000, 24'hFE0000, 24'hFEE000, 24'hFFC000, 24'hFFE000};
  localparam logic [23:0] BOOT_BASE [10] = '{
    24'h010000, 24'h020000, 24'h030000, 24'h040000, 24'h050000,
    24'h060000, 24'h070000, 24'h07E000, 24'h08C000, 24'h08E000};
  localparam logic [23:0] BLK_SIZE [10] = '{
    24'h010000, 24'h010000, 24'h010000, 24'h010000, 24'h010000,
    24'h010000, 24'h00E000, 24'h00E000, 24'h002000, 24'h002000};
  // Mode pin code for serial boot: {fa, fb, ma, mb}
  localparam logic [3:0] PINS_SERIAL_BOOT = 4'h5;
  localparam logic [3:0] PINS_SINGLE_CHIP = 4'h3;
  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP,
    MODE_SERIAL_BOOT,
    MODE_INVALID
  } op_mode_t;
endpackage

// ### tb/flash_array_model.sv
// Purpose: Flash array stand-in feeding read data
// Assumes: Data offered in the cycle of the read request
// Notes: Word pattern derived from the address
module flash_array_model (
  input wire logic [23:0] addr,
  output logic [31:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  assign data = {~addr[7:0], addr};
endmodule

// ### tb/tb.sv
// Purpose: Self-checking bench for mode latch and flash map
// Assumes: Random stimulus from a fixed xorshift seed
// Notes: Pins change after reset only to probe the mode latch
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, urq = 0, rd_req = 0, busy = 0, pgm_req = 0;
  logic [3:0] pins = 4'h0;
  logic [9:0] pset = 10'h000, pclr = 10'h000;
  logic [23:0] rd_addr = 24'h000000, pgm_addr = 24'h000000;
  logic [31:0] fdata, rd_data, seed = 32'h76146D74;
  logic mode_valid, serial_boot, fetch_boot_rom, user_rewrite, onboard_pgm;
  logic rd_hit, rd_blocked, pgm_grant, pgm_deny;
  logic [9:0] block_protect;
  logic [3:0] rd_block;
  int error_cnt = 0, samples_checked = 0;
  always #25 clk = ~clk;
  flash_array_model u_flash_array_model (.addr(rd_addr), .data(fdata));
  boot_mode_select_flash_map u_boot_mode_select_flash_map (
    .clk(clk), .srst(srst), .mode_sel_pin_a(pins[1]),
    .mode_sel_pin_b(pins[0]), .factory_sel_pin_a(pins[3]),
    .factory_sel_pin_b(pins[2]), .user_rewrite_req(urq),
    .protect_set(pset), .protect_clr(pclr), .rd_req(rd_req),
    .rd_addr(rd_addr), .flash_rdata(fdata), .flash_busy(busy),
    .pgm_req(pgm_req), .pgm_addr(pgm_addr), .mode_valid(mode_valid),
    .serial_boot(serial_boot), .fetch_boot_rom(fetch_boot_rom),
    .user_rewrite(user_rewrite), .onboard_pgm(onboard_pgm),
    .block_protect(block_protect), .rd_hit(rd_hit), .rd_block(rd_block),
    .rd_data(rd_data), .rd_blocked(rd_blocked), .pgm_grant(pgm_grant),
    .pgm_deny(pgm_deny));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [23:0] base(int i, logic boot);
    return boot ? boot_map_pkg::BOOT_BASE[i] : boot_map_pkg::CHIP_BASE[i];
  endfunction
  function automatic logic [4:0] map(logic [23:0] a, logic boot);
    for (int i = 0; i < 10; i++)
      if (24'(a - base(i, boot)) < boot_map_pkg::BLK_SIZE[i])
        return {1'b1, 4'(i)};
    return 5'h00;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (e !== s) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start(logic [3:0] p);
    pins <= p;
    srst <= 1'b1;
    tick(24);
    srst <= 1'b0;
    tick(3);
  endtask
  task automatic rd(logic [23:0] a, logic b, logic boot);
    logic [4:0] m;
    m = map(a, boot);
    rd_req <= 1'b1;
    rd_addr <= a;
    busy <= b;
    tick(1);
    rd_req <= 1'b0;
    tick(1);
    chk("rd_hit", m[4] & ~b, rd_hit);
    chk("rd_blocked", b, rd_blocked);
    if (b) chk("rd_data", 0, rd_data);
    if (m[4] & ~b) chk("rd_block", m[3:0], rd_block);
    if (m[4] & ~b) chk("rd_data", {~a[7:0], a}, rd_data);
  endtask
  task automatic pg(logic [23:0] a, logic g);
    pgm_req <= 1'b1;
    pgm_addr <= a;
    tick(1);
    pgm_req <= 1'b0;
    tick(1);
    chk("pgm_grant", g, pgm_grant);
    chk("pgm_deny", !g, pgm_deny);
  endtask
  task automatic sweep(logic boot);
    logic [23:0] b, s;
    for (int i = 0; i < 60; i++) begin
      b = base(i % 10, boot);
      s = boot_map_pkg::BLK_SIZE[i % 10];
      if (i < 10) rd(b, 1'b0, boot);
      else if (i < 20) rd(b + s - 24'h000001, 1'b0, boot);
      else rd(b + 24'(rnd() % s), 1'(rnd()), boot);
    end
    rd(base(0, !boot), 1'b0, boot);
    rd(base(0, boot) - 24'h000001, 1'b0, boot);
  endtask
  initial begin
    start(boot_map_pkg::PINS_SINGLE_CHIP);
    chk("fetch_boot_rom", 0, fetch_boot_rom);
    chk("onboard_pgm", 0, onboard_pgm);
    pg(24'hF80000, 1'b0);
    pins <= boot_map_pkg::PINS_SERIAL_BOOT;
    urq <= 1'b1;
    tick(1);
    urq <= 1'b0;
    pset <= 10'h200;
    tick(1);
    pset <= 10'h000;
    tick(2);
    chk("serial_boot", 0, serial_boot);
    chk("user_rewrite", 1, user_rewrite);
    chk("block_protect", 10'h200, block_protect);
    pg(24'hFFE000, 1'b0);
    pclr <= 10'h200;
    tick(3);
    pclr <= 10'h000;
    pg(24'hFFE000, 1'b1);
    pg(24'h010000, 1'b0);
    sweep(1'b0);
    start(boot_map_pkg::PINS_SERIAL_BOOT);
    chk("serial_boot", 1, serial_boot);
    chk("fetch_boot_rom", 1, fetch_boot_rom);
    pg(24'h08E000, 1'b1);
    sweep(1'b1);
    start(4'h0);
    chk("mode_valid", 0, mode_valid);
    wrap_up();
  end
  initial begin
    #200us;
    error_cnt++;
    wrap_up();
  end
endmodule
